// file: shared/aeds_pkg.sv
// Constants and types for the converter enable delay sequencer
//==============================================================
package aeds_pkg;

  //==============================================================
  // Timing
  localparam int unsigned AEDS_CLK_MHZ       = 100;
  localparam int unsigned AEDS_DLY_BASE_MHZ  = 16;
  localparam int unsigned AEDS_MAX_DLY_US    = 32;
  localparam int unsigned AEDS_MAX_DLY_TICKS =
    AEDS_MAX_DLY_US * AEDS_DLY_BASE_MHZ;
  // Ticks of the 16 MHz time base, derived from clk by a fractional
  // accumulator: add 16 each clk, tick when 100 is reached
  localparam int unsigned AEDS_TICK_STEP     = AEDS_DLY_BASE_MHZ;
  localparam int unsigned AEDS_TICK_MOD      = AEDS_CLK_MHZ;
  localparam int unsigned AEDS_CONV_NS10     = 625;
  localparam int unsigned AEDS_CLK_NS10      = 100;
  // Longest time rounds down
  localparam int unsigned AEDS_CONV_CYC      =
    AEDS_CONV_NS10 / AEDS_CLK_NS10;
  localparam int unsigned AEDS_CNT_W         = 10;

  //==============================================================
  // Reset values of the delay settings, staggered
  localparam logic [AEDS_CNT_W-1:0] AEDS_RST_REG_DLY   = 10'h000;
  localparam logic [AEDS_CNT_W-1:0] AEDS_RST_EN_DLY    = 10'h040;
  localparam logic [AEDS_CNT_W-1:0] AEDS_RST_START_DLY = 10'h080;

  //==============================================================
  typedef enum logic [1:0] {
    AEDS_IDLE = 2'b00,
    AEDS_RUN  = 2'b01,
    AEDS_CONV = 2'b10,
    AEDS_DONE = 2'b11
  } aeds_state_t;

endpackage

// file: verilog/aeds_sequencer.sv
// Delay counter staggering regulator, converter and start enables
`timescale 1ns/1ps
module aeds_sequencer
  import aeds_pkg::*;
#(
  parameter int unsigned CNT_W = AEDS_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             conv_regulator_enable,
  input  wire logic             converter_enable,
  input  wire logic             conversion_start_bit,
  input  wire logic             start_write,
  input  wire logic             delay_counter_enable,
  input  wire logic             dly_sel_regulator,
  input  wire logic             dly_sel_converter,
  input  wire logic             dly_sel_start,
  input  wire logic             dly_wr_a,
  input  wire logic [CNT_W-1:0] dly_wdata_regulator,
  input  wire logic [CNT_W-1:0] dly_wdata_converter,
  input  wire logic             dly_wr_b,
  input  wire logic [CNT_W-1:0] dly_wdata_start,
  output logic      [CNT_W-1:0] dly_regulator_q,
  output logic      [CNT_W-1:0] dly_converter_q,
  output logic      [CNT_W-1:0] dly_start_q,
  output logic                  regulator_out_q,
  output logic                  converter_out_q,
  output logic                  start_out_q,
  output logic                  conv_done_q,
  output logic                  counter_busy_q,
  output logic      [CNT_W-1:0] count_q
);

  //==============================================================
  // State
  aeds_state_t      state_q;
  logic [6:0]       acc_q;
  logic             tick;
  logic [2:0]       conv_cnt_q;
  logic             reached_reg;
  logic             reached_conv;
  logic             reached_start;
  logic             arm;
  logic [CNT_W-1:0] max_ticks;

  assign max_ticks = CNT_W'(AEDS_MAX_DLY_TICKS);
  assign tick = ({1'b0, acc_q} + 8'(AEDS_TICK_STEP)) >= 8'(AEDS_TICK_MOD);
  assign arm = start_write && conversion_start_bit && delay_counter_enable;

  // Signal reaches its delay, saturated at the 32 us limit
  function automatic logic reached(input logic [CNT_W-1:0] cnt,
                                   input logic [CNT_W-1:0] dly);
    reached = cnt >= ((dly > max_ticks) ? max_ticks : dly);
  endfunction

  assign reached_reg   = reached(count_q, dly_regulator_q);
  assign reached_conv  = reached(count_q, dly_converter_q);
  assign reached_start = reached(count_q, dly_start_q);

  //==============================================================
  // Delay settings
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dly_regulator_q <= AEDS_RST_REG_DLY;
      dly_converter_q <= AEDS_RST_EN_DLY;
      dly_start_q     <= AEDS_RST_START_DLY;
    end else begin
      if (dly_wr_a) begin
        dly_regulator_q <= dly_wdata_regulator;
        dly_converter_q <= dly_wdata_converter;
      end
      if (dly_wr_b) begin
        dly_start_q <= dly_wdata_start;
      end
    end
  end

  //==============================================================
  // 16 MHz time base
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= 7'h00;
    end else if (state_q != AEDS_RUN) begin
      acc_q <= 7'h00;
    end else if (tick) begin
      acc_q <= 7'(acc_q + 7'(AEDS_TICK_STEP) - 7'(AEDS_TICK_MOD));
    end else begin
      acc_q <= 7'(acc_q + 7'(AEDS_TICK_STEP));
    end
  end

  //==============================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q    <= AEDS_IDLE;
      count_q    <= '0;
      conv_cnt_q <= 3'h0;
    end else if (!delay_counter_enable) begin
      state_q    <= AEDS_IDLE;
      count_q    <= '0;
      conv_cnt_q <= 3'h0;
    end else begin
      unique case (state_q)
        AEDS_IDLE: begin
          if (arm) begin
            state_q <= AEDS_RUN;
          end
        end
        AEDS_RUN: begin
          if (reached_reg && reached_conv && reached_start) begin
            state_q    <= AEDS_CONV;
            conv_cnt_q <= 3'h0;
          end else if (tick) begin
            count_q <= count_q + 1'b1;
          end
        end
        AEDS_CONV: begin
          if (conv_cnt_q == 3'(AEDS_CONV_CYC - 1)) begin
            state_q <= AEDS_DONE;
          end else begin
            conv_cnt_q <= conv_cnt_q + 3'h1;
          end
        end
        AEDS_DONE: begin
          // Held until the enable is cleared
          state_q <= AEDS_DONE;
        end
      endcase
    end
  end

  //==============================================================
  // Outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regulator_out_q <= 1'b0;
      converter_out_q <= 1'b0;
      start_out_q     <= 1'b0;
      conv_done_q     <= 1'b0;
      counter_busy_q  <= 1'b0;
    end else begin
      // A gated signal waits for its count; an ungated one passes
      regulator_out_q <= conv_regulator_enable &&
        (!(dly_sel_regulator && delay_counter_enable) ||
         (state_q != AEDS_IDLE && reached_reg));
      converter_out_q <= converter_enable &&
        (!(dly_sel_converter && delay_counter_enable) ||
         (state_q != AEDS_IDLE && reached_conv));
      start_out_q <= conversion_start_bit &&
        (!(dly_sel_start && delay_counter_enable) ||
         (state_q == AEDS_RUN && reached_start) ||
         state_q == AEDS_CONV);
      conv_done_q    <= (state_q == AEDS_DONE);
      counter_busy_q <= (state_q == AEDS_RUN);
    end
  end

  //==============================================================
  // Checks
  a_arm_starts_run: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_q == AEDS_IDLE && arm |=> state_q == AEDS_RUN)
    else $error("armed start did not run the counter");
  a_done_holds: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_q == AEDS_DONE && delay_counter_enable
    |=> state_q == AEDS_DONE && $stable(count_q))
    else $error("counter moved after conversion end");
  a_done_flag: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_q == AEDS_DONE |=> conv_done_q)
    else $error("conversion end not flagged");
  a_clear_resets: assert property (
    @(posedge clk) disable iff (sys_rst)
    !delay_counter_enable |=> count_q == '0 && state_q == AEDS_IDLE)
    else $error("clearing enable did not reset counter");
  // Window of six enabled cycles matches the six-cycle conversion
  a_conv_length: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(state_q == AEDS_CONV) && delay_counter_enable
    ##1 delay_counter_enable[*5]
    |-> state_q == AEDS_CONV ##1 state_q == AEDS_DONE)
    else $error("conversion length wrong");
  a_count_bound: assert property (
    @(posedge clk) disable iff (sys_rst)
    count_q <= max_ticks)
    else $error("delay count beyond limit");
  a_limit_stops: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_q == AEDS_RUN && delay_counter_enable && count_q == max_ticks
    |=> state_q == AEDS_CONV)
    else $error("counter ran past the delay limit");
  a_undelayed_pass: assert property (
    @(posedge clk) disable iff (sys_rst)
    !(dly_sel_regulator && delay_counter_enable)
    |=> regulator_out_q == $past(conv_regulator_enable))
    else $error("ungated regulator enable not passed");
  a_gated_waits: assert property (
    @(posedge clk) disable iff (sys_rst)
    dly_sel_converter && delay_counter_enable && state_q == AEDS_IDLE
    |=> !converter_out_q)
    else $error("gated converter enable leaked early");
  a_reach_asserts: assert property (
    @(posedge clk) disable iff (sys_rst)
    converter_enable && dly_sel_converter && delay_counter_enable &&
    state_q != AEDS_IDLE && count_q >= dly_converter_q
    |=> converter_out_q)
    else $error("converter enable missed its delay");
  a_count_step: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_q == AEDS_RUN && delay_counter_enable &&
    $past(state_q) == AEDS_RUN
    |=> count_q - $past(count_q) <= 1)
    else $error("count advanced by more than one");
  a_reset_defaults: assert property (
    @(posedge clk)
    $past(sys_rst) && !dly_wr_a |-> dly_converter_q != dly_start_q)
    else $error("defaults not staggered");

  c_run: cover property (@(posedge clk) state_q == AEDS_RUN);
  c_done: cover property (@(posedge clk) conv_done_q);
  c_rearm: cover property (@(posedge clk)
    state_q == AEDS_DONE ##1 state_q == AEDS_IDLE);
  c_limit: cover property (@(posedge clk)
    state_q == AEDS_RUN && count_q == max_ticks);

endmodule

// file: verif/aeds_sw_model.sv
// Software model driving the delay-counter enable and conversion start
`timescale 1ns/1ps
module aeds_sw_model (
  input  wire logic clk,
  output logic      delay_counter_enable,
  output logic      start_write,
  output logic      conversion_start_bit
);
  //==============================================================
  // Idle levels
  initial begin
    delay_counter_enable = 1'b0;
    start_write          = 1'b0;
    conversion_start_bit = 1'b0;
  end

  //==============================================================
  // Software sequences
  // Typically called after the regulator was switched off
  task automatic disarm();
    @(posedge clk);
    #1 delay_counter_enable = 1'b0;
    // Read back zero before any re-arm
    while (delay_counter_enable !== 1'b0) @(posedge clk);
    @(posedge clk);
  endtask

  task automatic arm();
    @(posedge clk);
    #1 delay_counter_enable = 1'b1;
  endtask

  // Start bit stays high as a level; only the write strobe pulses
  task automatic start();
    @(posedge clk);
    #1 start_write = 1'b1;
    conversion_start_bit = 1'b1;
    @(posedge clk);
    #1 start_write = 1'b0;
  endtask
endmodule

// file: verif/aeds_sequencer_bench.sv
// Self-checking bench for the enable delay sequencer
`timescale 1ns/1ps
module aeds_sequencer_bench;
  import aeds_pkg::*;
  logic clk, sys_rst, conv_regulator_enable, converter_enable;
  logic conversion_start_bit, start_write, delay_counter_enable;
  logic dly_sel_regulator, dly_sel_converter, dly_sel_start;
  logic dly_wr_a, dly_wr_b, regulator_out_q, converter_out_q;
  logic start_out_q, conv_done_q, counter_busy_q;
  logic [9:0] dly_wdata_regulator, dly_wdata_converter, dly_wdata_start;
  logic [9:0] dly_regulator_q, dly_converter_q, dly_start_q, count_q;
  int err_count, num_checks, cyc, n;

  aeds_sw_model sw_u (.clk, .delay_counter_enable, .start_write,
    .conversion_start_bit);
  aeds_sequencer dut_u (.clk, .sys_rst, .conv_regulator_enable,
    .converter_enable, .conversion_start_bit, .start_write,
    .delay_counter_enable, .dly_sel_regulator, .dly_sel_converter,
    .dly_sel_start, .dly_wr_a, .dly_wdata_regulator, .dly_wdata_converter,
    .dly_wr_b, .dly_wdata_start, .dly_regulator_q, .dly_converter_q,
    .dly_start_q, .regulator_out_q, .converter_out_q, .start_out_q,
    .conv_done_q, .counter_busy_q, .count_q);

  //==============================================================
  // Clock, timeout and reporting
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs about 3300 cycles, most of them the 512-tick limit run; ceiling leaves margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  //==============================================================
  // Main sequence
  initial begin
    {sys_rst, conv_regulator_enable, converter_enable} = 3'h4;
    {dly_sel_regulator, dly_sel_converter, dly_sel_start} = 3'h7;
    {dly_wr_a, dly_wr_b} = 2'h0;
    {dly_wdata_regulator, dly_wdata_converter} = 20'h00000;
    dly_wdata_start = 10'h000;
    step(16);
    sys_rst = 1'b0;
    check(dly_regulator_q, AEDS_RST_REG_DLY);
    check(dly_converter_q, AEDS_RST_EN_DLY);
    check(dly_start_q, AEDS_RST_START_DLY);
    // Ungated path: enable of the counter low
    {conv_regulator_enable, converter_enable} = 2'h3;
    step(2);
    check({8'h00, regulator_out_q, converter_out_q}, 10'h003);
    {conv_regulator_enable, converter_enable} = 2'h0;
    {dly_wr_a, dly_wr_b} = 2'h3;
    {dly_wdata_regulator, dly_wdata_converter} = {10'h002, 10'h005};
    dly_wdata_start = 10'h3FF;
    step(1);
    {dly_wr_a, dly_wr_b} = 2'h0;
    step(1);
    // Readback keeps the raw value; the limit applies to the count
    check(dly_start_q, 10'h3FF);
    check(dly_converter_q, 10'h005);
    dly_wr_b = 1'b1;
    dly_wdata_start = 10'h008;
    step(1);
    dly_wr_b = 1'b0;
    // Delayed power-up sequence
    {conv_regulator_enable, converter_enable} = 2'h3;
    sw_u.arm();
    sw_u.start();
    for (n = 0; n < 300 && regulator_out_q !== 1'b1; n++) step(1);
    check({8'h00, converter_out_q, start_out_q}, 10'h000);
    check({9'h000, count_q >= 10'h002}, 10'h001);
    for (n = 0; n < 300 && converter_out_q !== 1'b1; n++) step(1);
    check({8'h00, regulator_out_q, start_out_q}, 10'h002);
    for (n = 0; n < 300 && start_out_q !== 1'b1; n++) step(1);
    check(count_q, 10'h008);
    for (n = 0; n < 300 && conv_done_q !== 1'b1; n++) step(1);
    check(10'(n), 10'(AEDS_CONV_CYC + 1));
    check({8'h00, counter_busy_q, conv_done_q}, 10'h001);
    step(20);
    check(count_q, 10'h008);
    // Start while done must be ignored
    sw_u.start();
    step(3);
    check({8'h00, counter_busy_q, conv_done_q}, 10'h001);
    {conv_regulator_enable, converter_enable} = 2'h0;
    sw_u.disarm();
    step(1);
    check(count_q, 10'h000);
    check({9'h000, conv_done_q}, 10'h000);
    // Start without the counter enabled does not run it
    sw_u.start();
    step(3);
    check({9'h000, counter_busy_q}, 10'h000);
    // Re-armed run: regulator ungated, start delay beyond the limit
    dly_sel_regulator = 1'b0;
    dly_wr_b = 1'b1;
    dly_wdata_start = 10'h3FF;
    step(1);
    dly_wr_b = 1'b0;
    {conv_regulator_enable, converter_enable} = 2'h3;
    sw_u.arm();
    sw_u.start();
    check({8'h00, regulator_out_q, converter_out_q}, 10'h002);
    for (n = 0; n < 4000 && conv_done_q !== 1'b1; n++) step(1);
    check(count_q, 10'h200);
    check({9'h000, conv_done_q}, 10'h001);
    summarize();
  end
endmodule
